/* File: pes_suspend_ctrl.sv */
// Program/erase suspend controller: link capture, suspend state, command gating
`default_nettype none


module pes_suspend_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic core_busy,
  input wire logic [1:0] core_kind,
  input wire logic [pes_pkg::SECTOR_W-1:0] core_sector,
  input wire logic core_page_op,
  input wire logic rd_active,
  input wire logic [pes_pkg::SECTOR_W-1:0] rd_sector,
  output logic halt_q,
  output logic resume_q,
  output logic resume_prog_q,
  output logic ready_q,
  output logic prog_suspended_buf_one_q,
  output logic prog_suspended_buf_two_q,
  output logic erase_suspended_flag_q,
  output logic read_undef_q,
  output logic prog_abort_q,
  output logic cmd_accept_q,
  output logic cmd_refuse_q,
  output logic [7:0] cmd_op_q,
  output logic [pes_pkg::SECTOR_W-1:0] cmd_sector_q,
  output logic abandon_q,
  output logic [pes_pkg::SECTOR_W-1:0] abandon_sector_q,
  output logic abandon_page_only_q
);

  localparam int SUSP_BOUND = pes_pkg::SUSP_CYC + 1;

  // ----------------------------------------------------------------
  // Link side, clocked by the host serial clock
  // ----------------------------------------------------------------
  // The serial clock stops between frames, so a marker armed by chip select
  // restarts the count at the next frame's first edge; the count survives
  // chip-select release, because the core clock reads it only after that.
  logic fresh_q;
  logic [5:0] bit_cnt_q;
  logic [31:0] shift_q;
  logic [7:0] op_l_q;

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  always_ff @(posedge sck) begin
    if (fresh_q) begin
      bit_cnt_q <= 6'h01;
    end else if (bit_cnt_q != 6'(pes_pkg::FRAME_BITS)) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge sck) begin
    if (fresh_q || bit_cnt_q != 6'(pes_pkg::FRAME_BITS)) begin
      shift_q <= {shift_q[30:0], mosi};
    end
    if (!fresh_q && bit_cnt_q == 6'(pes_pkg::OPC_BITS - 1)) begin
      op_l_q <= {shift_q[6:0], mosi};
    end
  end

  // ----------------------------------------------------------------
  // Frame hand-over into the core clock
  // ----------------------------------------------------------------
  // Link registers are quiet once chip select is high, so they are read only
  // after the synchronised rising edge of chip select.
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic frame_end;
  logic have_op;
  logic have_addr;
  logic [pes_pkg::SECTOR_W-1:0] frame_sector;
  pes_pkg::pes_class_e cls;

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  assign frame_end = cs_s2_q && !cs_s3_q;
  assign have_op = bit_cnt_q >= 6'(pes_pkg::OPC_BITS);
  assign have_addr = bit_cnt_q == 6'(pes_pkg::FRAME_BITS);
  assign frame_sector = shift_q[pes_pkg::SECTOR_MSB:pes_pkg::SECTOR_LSB];
  assign cls = pes_classify_w(op_l_q);

  function automatic pes_pkg::pes_class_e pes_classify_w(input logic [7:0] op);
    pes_classify_w = pes_pkg::pes_classify(op);
  endfunction

  // ----------------------------------------------------------------
  // Permission check
  // ----------------------------------------------------------------
  logic ps_any;
  logic susp_any;
  logic allowed;
  logic abort_hit;
  logic [pes_pkg::SECTOR_W-1:0] es_sector_q;

  assign ps_any = prog_suspended_buf_one_q || prog_suspended_buf_two_q;
  assign susp_any = ps_any || erase_suspended_flag_q;
  assign abort_hit = have_addr && erase_suspended_flag_q &&
                     frame_sector == es_sector_q;

  always_comb begin
    case (cls)
      pes_pkg::CL_READ: allowed = 1'b1;
      pes_pkg::CL_BUF1_WR: allowed = !prog_suspended_buf_one_q;
      pes_pkg::CL_BUF2_WR: allowed = !prog_suspended_buf_two_q;
      pes_pkg::CL_PROG_NOERASE: allowed = !ps_any && !abort_hit;
      pes_pkg::CL_PROG_ERASE: allowed = !susp_any;
      pes_pkg::CL_PROTECT: allowed = !susp_any;
      default: allowed = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_accept_q <= 1'b0;
      cmd_refuse_q <= 1'b0;
      prog_abort_q <= 1'b0;
      cmd_op_q <= 8'h00;
      cmd_sector_q <= '0;
    end else begin
      cmd_accept_q <= frame_end && have_op && allowed;
      cmd_refuse_q <= frame_end && have_op && !allowed;
      prog_abort_q <= frame_end && have_op && cls == pes_pkg::CL_PROG_NOERASE &&
                      !ps_any && abort_hit;
      if (frame_end && have_op) begin
        cmd_op_q <= op_l_q;
        cmd_sector_q <= frame_sector;
      end
    end
  end

  // ----------------------------------------------------------------
  // Suspend and resume sequencing
  // ----------------------------------------------------------------
  logic [15:0] susp_cnt_q;
  logic [15:0] res_cnt_q;
  logic [1:0] susp_kind_q;
  logic [pes_pkg::SECTOR_W-1:0] susp_sector_q;
  logic susp_page_q;
  logic [pes_pkg::SECTOR_W-1:0] ps_sector_q;
  logic es_page_q;
  logic go_suspend;
  logic go_resume;
  logic go_reset;
  logic susp_done;

  // A suspend during resume latency is dropped; the host polls status first
  assign go_suspend = frame_end && have_op && cls == pes_pkg::CL_SUSPEND && core_busy &&
                      susp_cnt_q == 16'h0000 && res_cnt_q == 16'h0000;
  assign go_resume = frame_end && have_op && cls == pes_pkg::CL_RESUME && susp_any &&
                     susp_cnt_q == 16'h0000;
  assign go_reset = frame_end && have_op && cls == pes_pkg::CL_RESET;
  assign susp_done = susp_cnt_q == 16'h0001;

  always_ff @(posedge clk) begin
    if (rst) begin
      susp_cnt_q <= 16'h0000;
      halt_q <= 1'b0;
      susp_kind_q <= pes_pkg::KIND_ERASE;
      susp_sector_q <= '0;
      susp_page_q <= 1'b0;
    end else if (go_suspend) begin
      susp_cnt_q <= 16'(pes_pkg::SUSP_CYC);
      halt_q <= 1'b1;
      susp_kind_q <= core_kind;
      susp_sector_q <= core_sector;
      susp_page_q <= core_page_op;
    end else if (susp_cnt_q != 16'h0000) begin
      susp_cnt_q <= susp_cnt_q - 16'h0001;
      halt_q <= !susp_done;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      res_cnt_q <= 16'h0000;
      resume_q <= 1'b0;
      resume_prog_q <= 1'b0;
    end else begin
      resume_q <= go_resume;
      if (go_resume) begin
        res_cnt_q <= 16'(pes_pkg::RES_CYC);
        resume_prog_q <= ps_any;
      end else if (res_cnt_q != 16'h0000) begin
        res_cnt_q <= res_cnt_q - 16'h0001;
      end
    end
  end

  // Hardware reset clears every flag: the parked work is simply lost
  always_ff @(posedge clk) begin
    if (rst || go_reset) begin
      prog_suspended_buf_one_q <= 1'b0;
      prog_suspended_buf_two_q <= 1'b0;
      erase_suspended_flag_q <= 1'b0;
    end else if (susp_done) begin
      case (susp_kind_q)
        pes_pkg::KIND_PROG_BUF1: prog_suspended_buf_one_q <= 1'b1;
        pes_pkg::KIND_PROG_BUF2: prog_suspended_buf_two_q <= 1'b1;
        pes_pkg::KIND_ERASE: erase_suspended_flag_q <= 1'b1;
        default: erase_suspended_flag_q <= erase_suspended_flag_q;
      endcase
    end else if (go_resume) begin
      if (ps_any) begin
        prog_suspended_buf_one_q <= 1'b0;
        prog_suspended_buf_two_q <= 1'b0;
      end else begin
        erase_suspended_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      es_sector_q <= '0;
      ps_sector_q <= '0;
      es_page_q <= 1'b0;
    end else if (susp_done) begin
      if (susp_kind_q == pes_pkg::KIND_ERASE) begin
        es_sector_q <= susp_sector_q;
        es_page_q <= susp_page_q;
      end else begin
        ps_sector_q <= susp_sector_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset command fallout
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      abandon_q <= 1'b0;
      abandon_sector_q <= '0;
      abandon_page_only_q <= 1'b0;
    end else begin
      abandon_q <= go_reset && susp_any;
      if (go_reset && erase_suspended_flag_q) begin
        abandon_sector_q <= es_sector_q;
        abandon_page_only_q <= es_page_q;
      end else if (go_reset && ps_any) begin
        abandon_sector_q <= ps_sector_q;
        abandon_page_only_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and read guard
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_q <= 1'b0;
      read_undef_q <= 1'b0;
    end else begin
      ready_q <= !core_busy && susp_cnt_q == 16'h0000 && res_cnt_q == 16'h0000;
      read_undef_q <= rd_active &&
                      ((erase_suspended_flag_q && rd_sector == es_sector_q) ||
                       (ps_any && rd_sector == ps_sector_q));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_halt_window;
    $rose(halt_q) ##[1:SUSP_BOUND] $fell(halt_q);
  endsequence

  sequence s_erase_park;
    susp_done && susp_kind_q == pes_pkg::KIND_ERASE ##1 erase_suspended_flag_q;
  endsequence

  susp_latency_a: assert property (@(posedge clk) disable iff (rst)
    $rose(halt_q) |-> s_halt_window)
    else $error("Suspend did not complete within latency");

  flag_set_a: assert property (@(posedge clk) disable iff (rst)
    susp_done && susp_kind_q == pes_pkg::KIND_ERASE && !go_reset |-> s_erase_park)
    else $error("Erase flag not set after suspend");

  ready_after_a: assert property (@(posedge clk) disable iff (rst)
    $fell(halt_q) && !core_busy && res_cnt_q == 16'h0000 |=> ready_q)
    else $error("Ready not reported after suspend");

  abort_refuse_a: assert property (@(posedge clk) disable iff (rst)
    prog_abort_q |-> cmd_refuse_q && $past(erase_suspended_flag_q))
    else $error("Abort without refusal or erase suspend");

  resume_order_a: assert property (@(posedge clk) disable iff (rst)
    go_resume && ps_any && erase_suspended_flag_q && !go_reset
      |=> erase_suspended_flag_q && !prog_suspended_buf_one_q && resume_prog_q)
    else $error("Erase resumed before program");

  undef_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_active && erase_suspended_flag_q && rd_sector == es_sector_q |=> read_undef_q)
    else $error("Read of suspended sector not flagged");

  valid_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_active && !susp_any |=> !read_undef_q)
    else $error("Unsuspended read flagged undefined");

  reads_kept_a: assert property (@(posedge clk) disable iff (rst)
    cmd_refuse_q |-> pes_pkg::pes_classify(cmd_op_q) != pes_pkg::CL_READ)
    else $error("Read command refused");

  erase_refused_a: assert property (@(posedge clk) disable iff (rst)
    frame_end && have_op && susp_any &&
      (cls == pes_pkg::CL_PROG_ERASE || cls == pes_pkg::CL_PROTECT)
      |=> cmd_refuse_q && !cmd_accept_q)
    else $error("Erase or protection change accepted while suspended");

  refuse_still_a: assert property (@(posedge clk) disable iff (rst)
    frame_end && have_op && !allowed && !susp_done
      |=> $stable(erase_suspended_flag_q) && $stable(prog_suspended_buf_one_q))
    else $error("Refused command changed flags");

  no_susp_resume_a: assert property (@(posedge clk) disable iff (rst)
    res_cnt_q != 16'h0000 |=> !$rose(halt_q))
    else $error("Suspend taken during resume latency");

endmodule // pes_suspend_ctrl

`default_nettype wire

/* File: pes_pkg.sv */
// Shared constants, types and decode helpers for the suspend controller
`default_nettype none

package pes_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  // Suspend and resume latencies have no printed figure here; plain defaults
  localparam int SUSPEND_LATENCY_NS = 20000;
  localparam int RESUME_LATENCY_NS = 20000;
  // Longest times round down, never below one cycle
  localparam int SUSP_CYC = (SUSPEND_LATENCY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                            (SUSPEND_LATENCY_NS / CLK_PERIOD_NS);
  localparam int RES_CYC = (RESUME_LATENCY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                           (RESUME_LATENCY_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int OPC_BITS = 8;
  localparam int FRAME_BITS = 32;
  localparam int SECTOR_MSB = 20;
  localparam int SECTOR_LSB = 17;
  localparam int SECTOR_W = SECTOR_MSB - SECTOR_LSB + 1;

  // ----------------------------------------------------------------
  // Opcodes (first byte of each command)
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_SUSPEND = 8'hb0;
  localparam logic [7:0] OPC_RESUME = 8'hd0;
  localparam logic [7:0] OPC_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OPC_PROTECT = 8'h3d;
  localparam logic [7:0] OPC_SECT_ERASE = 8'h7c;
  // Remaining opcode values are arbitrary stand-ins for the opcode map
  localparam logic [7:0] OPC_READ_ARRAY = 8'h01;
  localparam logic [7:0] OPC_READ_BUF1 = 8'h02;
  localparam logic [7:0] OPC_READ_BUF2 = 8'h03;
  localparam logic [7:0] OPC_READ_STATUS = 8'h04;
  localparam logic [7:0] OPC_READ_PROT = 8'h05;
  localparam logic [7:0] OPC_READ_LOCK = 8'h06;
  localparam logic [7:0] OPC_BUF1_WRITE = 8'h11;
  localparam logic [7:0] OPC_BUF2_WRITE = 8'h12;
  localparam logic [7:0] OPC_B1_PROG_NE = 8'h13;
  localparam logic [7:0] OPC_B2_PROG_NE = 8'h14;
  localparam logic [7:0] OPC_THRU_B1_NE = 8'h15;
  localparam logic [7:0] OPC_B1_PROG_E = 8'h16;
  localparam logic [7:0] OPC_B2_PROG_E = 8'h17;
  localparam logic [7:0] OPC_THRU_B1_E = 8'h18;
  localparam logic [7:0] OPC_THRU_B2_E = 8'h19;
  localparam logic [7:0] OPC_PAGE_REWRITE = 8'h1a;
  localparam logic [7:0] OPC_PAGE_ERASE = 8'h1b;
  localparam logic [7:0] OPC_BLOCK_ERASE = 8'h1c;
  localparam logic [7:0] OPC_LOCKDOWN = 8'h1d;
  localparam logic [7:0] OPC_RESET_CMD = 8'h1e;

  typedef enum logic [3:0] {
    CL_OTHER, CL_READ, CL_BUF1_WR, CL_BUF2_WR, CL_PROG_NOERASE,
    CL_PROG_ERASE, CL_PROTECT, CL_SUSPEND, CL_RESUME, CL_RESET
  } pes_class_e;

  typedef enum logic [1:0] {KIND_PROG_BUF1, KIND_PROG_BUF2, KIND_ERASE} pes_kind_e;

  function automatic pes_class_e pes_classify(input logic [7:0] op);
    case (op)
      OPC_READ_ARRAY, OPC_READ_BUF1, OPC_READ_BUF2, OPC_READ_STATUS,
      OPC_READ_PROT, OPC_READ_LOCK: pes_classify = CL_READ;
      OPC_BUF1_WRITE: pes_classify = CL_BUF1_WR;
      OPC_BUF2_WRITE: pes_classify = CL_BUF2_WR;
      OPC_B1_PROG_NE, OPC_B2_PROG_NE, OPC_THRU_B1_NE: pes_classify = CL_PROG_NOERASE;
      OPC_B1_PROG_E, OPC_B2_PROG_E, OPC_THRU_B1_E, OPC_THRU_B2_E, OPC_PAGE_REWRITE,
      OPC_PAGE_ERASE, OPC_BLOCK_ERASE, OPC_SECT_ERASE,
      OPC_CHIP_ERASE: pes_classify = CL_PROG_ERASE;
      OPC_PROTECT, OPC_LOCKDOWN: pes_classify = CL_PROTECT;
      OPC_SUSPEND: pes_classify = CL_SUSPEND;
      OPC_RESUME: pes_classify = CL_RESUME;
      OPC_RESET_CMD: pes_classify = CL_RESET;
      default: pes_classify = CL_OTHER;
    endcase
  endfunction

endpackage

`default_nettype wire

/* File: pes_host_model.sv */
// Host-side serial command source that drives the suspend controller's link
`default_nettype none

module pes_host_model (
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  timeunit 1ns;
  timeprecision 1ps;

  // Serial clock stands low outside frames; chip select starts low for a
  // moment so that its first rise arms the device's frame marker
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b1;
    #1 cs_n = 1'b1;
  end

  // Opcode, 24 address bits, then one junk byte the device must ignore
  task automatic send(input logic [39:0] bits);
    cs_n = 1'b0;
    for (int i = 39; i >= 0; i--) begin
      mosi = bits[i];
      #16 sck = 1'b1;
      #16 sck = 1'b0;
    end
    #16 cs_n = 1'b1;
    // Released line shows the inverse, so a stale bit is never trusted
    mosi = ~mosi;
  endtask

endmodule // pes_host_model

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the program/erase suspend controller
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, sck, cs_n, mosi, core_busy, core_page_op, rd_active;
  logic [1:0] core_kind;
  logic [pes_pkg::SECTOR_W-1:0] core_sector, rd_sector, abandon_sector_q, cmd_sector_q;
  logic [7:0] cmd_op_q;
  logic halt_q, resume_q, resume_prog_q, ready_q, flag_b1, flag_b2, flag_er;
  logic read_undef_q, prog_abort_q, cmd_accept_q, cmd_refuse_q, abandon_q, abandon_page_only_q;
  logic acc_s, ref_s, abt_s, res_s, res_prog, abn_s, halt_s;
  int mismatches, tests_run;

  // ----------------------------------------------------------------
  // Command table: opcode, accepted in erase suspend, accepted in buffer-two suspend
  // ----------------------------------------------------------------
  localparam logic [9:0] ROWS [22] = '{
    {8'h01, 2'b11}, {8'h02, 2'b11}, {8'h03, 2'b11}, {8'h04, 2'b11}, {8'h05, 2'b11},
    {8'h06, 2'b11}, {8'h11, 2'b11}, {8'h12, 2'b10}, {8'h13, 2'b10}, {8'h14, 2'b10},
    {8'h15, 2'b10}, {8'h16, 2'b00}, {8'h17, 2'b00}, {8'h18, 2'b00}, {8'h19, 2'b00},
    {8'h1a, 2'b00}, {8'h1b, 2'b00}, {8'h1c, 2'b00}, {8'h7c, 2'b00}, {8'hc7, 2'b00},
    {8'h3d, 2'b00}, {8'h1d, 2'b00}};

  pes_host_model u_pes_host_model (.sck(sck), .cs_n(cs_n), .mosi(mosi));

  pes_suspend_ctrl u_pes_suspend_ctrl (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .core_busy(core_busy),
    .core_kind(core_kind), .core_sector(core_sector), .core_page_op(core_page_op),
    .rd_active(rd_active), .rd_sector(rd_sector), .halt_q(halt_q), .resume_q(resume_q),
    .resume_prog_q(resume_prog_q), .ready_q(ready_q), .prog_suspended_buf_one_q(flag_b1),
    .prog_suspended_buf_two_q(flag_b2), .erase_suspended_flag_q(flag_er),
    .read_undef_q(read_undef_q), .prog_abort_q(prog_abort_q), .cmd_accept_q(cmd_accept_q),
    .cmd_refuse_q(cmd_refuse_q), .cmd_op_q(cmd_op_q), .cmd_sector_q(cmd_sector_q),
    .abandon_q(abandon_q),
    .abandon_sector_q(abandon_sector_q), .abandon_page_only_q(abandon_page_only_q));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pulses last one cycle, so they are latched here and read after the frame
  always @(posedge clk) begin
    if (cmd_accept_q) acc_s <= 1'b1;
    if (cmd_refuse_q) ref_s <= 1'b1;
    if (prog_abort_q) abt_s <= 1'b1;
    if (abandon_q) abn_s <= 1'b1;
    if (halt_q) halt_s <= 1'b1;
    if (resume_q) begin
      res_s <= 1'b1;
      res_prog <= resume_prog_q;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic frame(input logic [7:0] op, input logic [3:0] sec);
    {acc_s, ref_s, abt_s, res_s, abn_s, halt_s} = '0;
    u_pes_host_model.send({op, 3'h0, sec, 17'h0, 8'ha5});
    for (int i = 0; i < 20 && !(acc_s || ref_s); i++) tick(1);
    tick(2);
  endtask

  task automatic do_reset;
    rst = 1'b1;
    tick(20);
    chk("reset_outs", 8'h0, {4'h0, ready_q, flag_b1, flag_b2, flag_er});
    rst = 1'b0;
    tick(3);
  endtask

  // Engine keeps running until the flag shows, then parks and goes idle
  task automatic suspend(input logic [1:0] kind, input logic [3:0] sec);
    int i;
    core_busy = 1'b1;
    core_kind = kind;
    core_sector = sec;
    frame(pes_pkg::OPC_SUSPEND, 4'h0);
    chk("halt", 8'h1, {7'h0, halt_s});
    for (i = 0; i < 900 && halt_q === 1'b1; i++) tick(1);
    chk("latency", 8'h1, {7'h0, i < pes_pkg::SUSP_CYC});
    core_busy = 1'b0;
    tick(3);
    chk("ready", 8'h1, {7'h0, ready_q});
  endtask

  task automatic run_rows(input logic ps_col);
    logic [2:0] flags;
    logic e;
    flags = {flag_b1, flag_b2, flag_er};
    foreach (ROWS[r]) begin
      e = ps_col ? ROWS[r][0] : ROWS[r][1];
      frame(ROWS[r][9:2], 4'h5);
      chk($sformatf("gate_%h", ROWS[r][9:2]), {6'h0, e, ~e}, {6'h0, acc_s, ref_s});
      chk("flags_kept", {5'h0, flags}, {5'h0, flag_b1, flag_b2, flag_er});
    end
  endtask

  task automatic conclude;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, core_busy, core_page_op, rd_active} = 4'hf;
    {core_busy, core_page_op, rd_active} = 3'h0;
    {core_kind, core_sector, rd_sector} = '0;
    {acc_s, ref_s, abt_s, res_s, res_prog, abn_s, halt_s} = '0;
    mismatches = 0;
    tests_run = 0;
    do_reset;
    // Nothing running, so a suspend must not halt anything
    frame(pes_pkg::OPC_SUSPEND, 4'h0);
    chk("idle_suspend", 8'h0, {4'h0, halt_s, flag_b1, flag_b2, flag_er});
    suspend(2'd1, 4'h6);
    chk("flags_b2", 8'h2, {5'h0, flag_b1, flag_b2, flag_er});
    run_rows(1'b1);
    frame(pes_pkg::OPC_RESUME, 4'h0);
    chk("resume", 8'h3, {6'h0, res_s, res_prog});
    chk("resume_flags", 8'h0, {4'h0, ready_q, flag_b1, flag_b2, flag_er});
    tick(pes_pkg::RES_CYC + 5);
    do_reset;
    suspend(2'd2, 4'h3);
    chk("flags_er", 8'h1, {5'h0, flag_b1, flag_b2, flag_er});
    rd_active = 1'b1;
    rd_sector = 4'h3;
    tick(2);
    chk("undef_in", 8'h1, {7'h0, read_undef_q});
    rd_sector = 4'h4;
    tick(2);
    chk("undef_out", 8'h0, {7'h0, read_undef_q});
    rd_active = 1'b0;
    run_rows(1'b0);
    frame(pes_pkg::OPC_B1_PROG_NE, 4'h3);
    chk("abort", 8'h3, {6'h0, abt_s, ref_s});
    chk("abort_flags", 8'h1, {5'h0, flag_b1, flag_b2, flag_er});
    chk("cmd_op", pes_pkg::OPC_B1_PROG_NE, cmd_op_q);
    chk("cmd_sector", 8'h3, {4'h0, cmd_sector_q});
    suspend(2'd0, 4'h5);
    chk("both_flags", 8'h5, {5'h0, flag_b1, flag_b2, flag_er});
    frame(pes_pkg::OPC_RESUME, 4'h0);
    chk("prog_first", 8'h3, {6'h0, res_s, res_prog});
    chk("erase_kept", 8'h1, {5'h0, flag_b1, flag_b2, flag_er});
    frame(pes_pkg::OPC_RESET_CMD, 4'h0);
    chk("abandon_sect", 8'h26, {2'h0, abn_s, abandon_sector_q, abandon_page_only_q});
    chk("abandon_flags", 8'h0, {5'h0, flag_b1, flag_b2, flag_er});
    do_reset;
    core_page_op = 1'b1;
    suspend(2'd0, 4'h2);
    frame(pes_pkg::OPC_RESET_CMD, 4'h0);
    chk("abandon_page", 8'h25, {2'h0, abn_s, abandon_sector_q, abandon_page_only_q});
    // Hardware reset while an erase is parked must drop every flag
    suspend(2'd2, 4'h7);
    do_reset;
    conclude;
  end

  // Whole run is near 8000 cycles; this cuts a hang well beyond that
  initial begin
    #1_000_000;
    mismatches++;
    conclude;
  end

endmodule // tb_top

`default_nettype wire
